// ==== shared/fts_pkg.sv ====
package fts_pkg;
  // register addresses seen by the serial port
  localparam logic [14:0] FTS_ADDR_CTRL = 15'h0000;
  localparam logic [14:0] FTS_ADDR_BYTE_LOW = 15'h0001;
  localparam logic [14:0] FTS_ADDR_BYTE_ONE = 15'h0002;
  localparam logic [14:0] FTS_ADDR_BYTE_TWO = 15'h0003;
  localparam logic [14:0] FTS_ADDR_BYTE_HIGH = 15'h0004;
  localparam logic [7:0] FTS_CTRL_RST = 8'h00;
  localparam logic [7:0] FTS_CTRL_WMASK = 8'h1F;
  localparam logic [7:0] FTS_UNMAPPED = 8'h00;
  localparam logic [31:0] FTS_CNT_RST = 32'h0000_0000;
  // counting rate against the system clock, in MHz
  localparam int FTS_SYS_MHZ = 100;
  localparam int FTS_CNT_MHZ = 32;
  localparam logic [6:0] FTS_ACC_STEP = 7'(FTS_CNT_MHZ);
  localparam logic [6:0] FTS_ACC_WRAP = 7'(FTS_SYS_MHZ);
  localparam logic [6:0] FTS_ACC_RST = 7'h00;
  // serial frame: one write flag, 15 address bits, then data bytes
  localparam logic [4:0] FTS_HDR_BITS = 5'h10;
  localparam logic [4:0] FTS_BYTE_BITS = 5'h08;
  localparam int FTS_HDR_WFLAG = 15;
  localparam int FTS_BYTE_MSB = 7;

  typedef struct packed {
    logic [2:0] reserved;
    logic capture_on_tx_start;
    logic capture_on_rx_frame_start;
    logic clear_on_tx_start;
    logic clear_on_rx_frame_start;
    logic enable;
  } fts_ctrl_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } fts_spi_in_t;

  typedef enum logic [1:0] {
    FTS_IDLE = 2'b00,
    FTS_HDR = 2'b01,
    FTS_DATA = 2'b10
  } fts_state_t;
endpackage

// ==== hw/fts_counter.sv ====
`timescale 1ns/1ps
module fts_counter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // baseband state machine
  input wire logic pa_enable_i,
  input wire logic rx_frame_start_irq_i,
  input wire logic trx_halt_i,
  // serial control pins
  input wire fts_pkg::fts_spi_in_t spi_i,
  output logic miso_o,
  output logic miso_oe_o
);
  import fts_pkg::*;

  fts_ctrl_t ctrl_ff;
  logic [31:0] cnt_ff;
  logic [31:0] cap_ff;
  logic [31:0] snap_ff;
  logic [6:0] acc_ff;
  logic tick_ff;
  logic pa_prev_ff;
  fts_spi_in_t sync1_ff;
  fts_spi_in_t sync2_ff;
  fts_spi_in_t sync3_ff;
  fts_state_t state_ff;
  logic [4:0] bits_ff;
  logic [15:0] hdr_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [14:0] addr_ff;
  logic miso_ff;
  logic miso_oe_ff;

  logic tx_start;
  logic rx_start;
  logic [31:0] shown;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_high;
  logic [7:0] nxt_rx_sh;
  logic [15:0] nxt_hdr;
  logic [7:0] nxt_acc;

  function automatic logic [7:0] reg_read(input logic [14:0] addr,
                                          input fts_ctrl_t ctrl,
                                          input logic [31:0] snap);
    logic [7:0] data;
    data = FTS_UNMAPPED;
    unique case (addr)
      FTS_ADDR_CTRL: data = ctrl;
      FTS_ADDR_BYTE_LOW: data = snap[7:0];
      FTS_ADDR_BYTE_ONE: data = snap[15:8];
      FTS_ADDR_BYTE_TWO: data = snap[23:16];
      FTS_ADDR_BYTE_HIGH: data = snap[31:24];
      default: data = FTS_UNMAPPED;
    endcase
    return data;
  endfunction

  assign tx_start = pa_enable_i & ~pa_prev_ff;
  assign rx_start = rx_frame_start_irq_i;
  assign shown = (ctrl_ff.capture_on_tx_start | ctrl_ff.capture_on_rx_frame_start)
                 ? cap_ff : cnt_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_prev_ff <= 1'b0;
    end else begin
      pa_prev_ff <= pa_enable_i;
    end
  end

  // fractional divider: 32 ticks every 100 system cycles, never two in a row
  assign nxt_acc = {1'b0, acc_ff} + {1'b0, FTS_ACC_STEP};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= FTS_ACC_RST;
      tick_ff <= 1'b0;
    end else if (nxt_acc >= {1'b0, FTS_ACC_WRAP}) begin
      acc_ff <= 7'(nxt_acc - {1'b0, FTS_ACC_WRAP});
      tick_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc[6:0];
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= FTS_CNT_RST;
    end else if (!ctrl_ff.enable) begin
      cnt_ff <= FTS_CNT_RST;
    end else if (ctrl_ff.clear_on_tx_start && tx_start) begin
      cnt_ff <= FTS_CNT_RST;
    end else if (ctrl_ff.clear_on_rx_frame_start && rx_start) begin
      cnt_ff <= FTS_CNT_RST;
    end else if (tick_ff && !trx_halt_i) begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  // capture sees the value before any clear from the same event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_ff <= FTS_CNT_RST;
    end else if (ctrl_ff.capture_on_tx_start && tx_start) begin
      cap_ff <= cnt_ff;
    end else if (ctrl_ff.capture_on_rx_frame_start && rx_start) begin
      cap_ff <= cnt_ff;
    end
  end

  // pins are asynchronous: two flops before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
      sync2_ff <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
      sync3_ff <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
    end else begin
      sync1_ff <= spi_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign sclk_rise = sync2_ff.sclk & ~sync3_ff.sclk;
  assign sclk_fall = ~sync2_ff.sclk & sync3_ff.sclk;
  assign cs_fall = ~sync2_ff.cs_n & sync3_ff.cs_n;
  assign cs_high = sync2_ff.cs_n;
  assign nxt_rx_sh = {rx_sh_ff[6:0], sync2_ff.mosi};
  assign nxt_hdr = {hdr_ff[14:0], sync2_ff.mosi};

  // one snapshot per frame keeps a block read coherent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snap_ff <= FTS_CNT_RST;
    end else if (cs_fall) begin
      snap_ff <= shown;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= FTS_IDLE;
      bits_ff <= 5'h00;
      hdr_ff <= 16'h0000;
      rx_sh_ff <= 8'h00;
      addr_ff <= FTS_ADDR_CTRL;
    end else if (cs_high) begin
      state_ff <= FTS_IDLE;
      bits_ff <= 5'h00;
    end else begin
      unique case (state_ff)
        FTS_IDLE: begin
          state_ff <= FTS_HDR;
          bits_ff <= 5'h00;
        end
        FTS_HDR: begin
          if (sclk_rise) begin
            hdr_ff <= nxt_hdr;
            if (bits_ff == FTS_HDR_BITS - 5'h01) begin
              state_ff <= FTS_DATA;
              addr_ff <= nxt_hdr[14:0];
              bits_ff <= 5'h00;
            end else begin
              bits_ff <= bits_ff + 5'h01;
            end
          end
        end
        FTS_DATA: begin
          if (sclk_rise) begin
            rx_sh_ff <= nxt_rx_sh;
            if (bits_ff == FTS_BYTE_BITS - 5'h01) begin
              addr_ff <= addr_ff + 15'h0001; // block access walks the map
              bits_ff <= 5'h00;
            end else begin
              bits_ff <= bits_ff + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // only the control register takes writes; reserved bits stay zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= FTS_CTRL_RST;
    end else if (!cs_high && state_ff == FTS_DATA && sclk_rise
                 && bits_ff == FTS_BYTE_BITS - 5'h01 && hdr_ff[FTS_HDR_WFLAG]
                 && addr_ff == FTS_ADDR_CTRL) begin
      ctrl_ff <= nxt_rx_sh & FTS_CTRL_WMASK;
    end
  end

  // read byte loaded at each byte boundary, shifted out on falling sclk
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_ff <= 8'h00;
      miso_ff <= 1'b0;
    end else if (!cs_high && sclk_rise && state_ff == FTS_HDR
                 && bits_ff == FTS_HDR_BITS - 5'h01) begin
      tx_sh_ff <= reg_read(nxt_hdr[14:0], ctrl_ff, snap_ff);
    end else if (!cs_high && sclk_rise && state_ff == FTS_DATA
                 && bits_ff == FTS_BYTE_BITS - 5'h01) begin
      tx_sh_ff <= reg_read(addr_ff + 15'h0001, ctrl_ff, snap_ff);
    end else if (!cs_high && sclk_fall && state_ff == FTS_DATA) begin
      miso_ff <= tx_sh_ff[FTS_BYTE_MSB];
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= ~cs_high;
    end
  end

  assign miso_o = miso_ff;
  assign miso_oe_o = miso_oe_ff;

  dis_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_ff.enable |=> cnt_ff == FTS_CNT_RST) else $error("counter not zero while disabled");
  run_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.enable && tick_ff && !trx_halt_i && !tx_start && !rx_start
    |=> cnt_ff == $past(cnt_ff) + 32'h0000_0001) else $error("counter did not advance");
  tick_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_ff |=> !tick_ff ##1 !tick_ff) else $error("count tick faster than 32 MHz");
  tx_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.clear_on_tx_start && tx_start |=> cnt_ff == FTS_CNT_RST)
    else $error("tx start did not clear");
  rx_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.clear_on_rx_frame_start && rx_frame_start_irq_i |=> cnt_ff == FTS_CNT_RST)
    else $error("rx frame start did not clear");
  no_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.enable && !ctrl_ff.clear_on_tx_start && !ctrl_ff.clear_on_rx_frame_start
    && !tick_ff |=> $stable(cnt_ff)) else $error("counter moved without a tick");
  halt_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.enable && trx_halt_i && !tx_start && !rx_start |=> $stable(cnt_ff))
    else $error("counter ran while halted");
  wrap_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.enable && tick_ff && !trx_halt_i && cnt_ff == 32'hFFFF_FFFF
    |=> cnt_ff == FTS_CNT_RST) else $error("counter did not wrap");
  cap_tx_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.capture_on_tx_start && tx_start |=> cap_ff == $past(cnt_ff))
    else $error("tx capture missed");
  cap_rx_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_ff.capture_on_rx_frame_start && rx_frame_start_irq_i && !tx_start
    |=> cap_ff == $past(cnt_ff)) else $error("rx capture missed");
  tx_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_start |=> !tx_start) else $error("tx start longer than one cycle");
  snap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sync2_ff.cs_n && !sync3_ff.cs_n |=> $stable(snap_ff)) else $error("snapshot moved in frame");
endmodule

// ==== tb/fts_host.sv ====
`timescale 1ns/1ps
module fts_host
  import fts_pkg::*;
(
  // clock
  input wire logic clk_i,
  // serial pins
  output fts_spi_in_t spi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic last_q = 1'b0;
  // a released line shows the inverse, never a stale value
  wire logic line = miso_oe_i ? miso_i : ~last_q;
  initial spi_o = '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // whole block in one select, so every byte shares one snapshot
  task automatic frame(input logic wr, input logic [14:0] a, input logic [31:0] wd,
                       input int nb, output logic [31:0] rd);
    logic [47:0] tx;
    tx = {wr, a, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
    rd = '0;
    spi_o.cs_n <= 1'b0;
    tick(5);
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      spi_o.mosi <= tx[47 - i];
      spi_o.sclk <= 1'b0;
      tick(5);
      spi_o.sclk <= 1'b1;
      last_q <= line;
      if (i >= 16) rd[8 * ((i - 16) / 8) + 7 - (i % 8)] = line;
      tick(5);
    end
    spi_o.sclk <= 1'b0;
    tick(5);
    spi_o.cs_n <= 1'b1;
    tick(5);
  endtask
endmodule

// ==== tb/test_frame_timestamp_counter.sv ====
`timescale 1ns/1ps
module test_frame_timestamp_counter;
  import fts_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pa_en = 1'b0;
  logic rx_fs = 1'b0;
  logic halt = 1'b0;
  fts_spi_in_t spi;
  logic miso;
  logic miso_oe;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0 = 0;
  int v;
  int ct;
  logic [15:0] seed = 16'h0016;
  logic [31:0] rd;
  logic [31:0] h;
  always #5 clk_i = ~clk_i;
  fts_counter fts_counter_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .pa_enable_i(pa_en),
    .rx_frame_start_irq_i(rx_fs), .trx_halt_i(halt), .spi_i(spi), .miso_o(miso),
    .miso_oe_o(miso_oe));
  fts_host fts_host_inst (.clk_i(clk_i), .spi_o(spi), .miso_i(miso), .miso_oe_i(miso_oe));
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // tick is jittered, so a few counts either way are accepted
  function automatic logic [31:0] cnt_of(input logic [31:0] seen, input int d);
    logic [31:0] e;
    e = 32'(d * 32 / 100);
    return ((seen + 4 - e) <= 8) === 1'b1 ? seen : e;
  endfunction
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    fts_host_inst.frame(1'b1, a, {24'h0, d}, 1, rd);
  endtask
  task automatic rd_n(input logic [14:0] a, input int n);
    fts_host_inst.frame(1'b0, a, 32'h0, n, rd);
  endtask
  // snapshot lands about three clocks after select falls
  task automatic rdc();
    v = cyc - t0 + 3;
    rd_n(FTS_ADDR_BYTE_LOW, 4);
  endtask
  task automatic evt(input logic tx);
    pa_en <= 1'b0;
    @(posedge clk_i);
    pa_en <= tx;
    rx_fs <= ~tx;
    @(posedge clk_i);
    rx_fs <= 1'b0;
  endtask
  task automatic rwait();
    seed = lfsr(seed);
    repeat (100 + seed[8:0]) @(posedge clk_i);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_n(FTS_ADDR_CTRL, 1);
    check("control", rd, 32'(FTS_CTRL_RST));
    check("released", 32'(miso_oe), 32'h0);
    rdc();
    check("count", rd, 32'h0);
    repeat (4) begin
      seed = lfsr(seed);
      wr(FTS_ADDR_CTRL, seed[7:0]);
      rd_n(FTS_ADDR_CTRL, 1);
      check("control", rd, 32'(seed[7:0] & FTS_CTRL_WMASK));
    end
    wr(FTS_ADDR_CTRL, 8'h00);
    wr(FTS_ADDR_BYTE_ONE, 8'hA5);
    rdc();
    check("read only", rd, 32'h0);
    rd_n(15'h0005, 1);
    check("unmapped", rd, 32'(FTS_UNMAPPED));
    wr(FTS_ADDR_CTRL, 8'h01);
    // enable lands 3 clocks after the last data rise, 12 clocks before the write returns
    t0 = cyc - 11;
    rwait();
    rdc();
    check("free run", rd, cnt_of(rd, v));
    wr(FTS_ADDR_CTRL, 8'h03);
    evt(1'b0);
    t0 = cyc;
    rwait();
    rdc();
    check("rx clear", rd, cnt_of(rd, v));
    wr(FTS_ADDR_CTRL, 8'h05);
    evt(1'b1);
    t0 = cyc;
    rwait();
    rdc();
    check("tx clear", rd, cnt_of(rd, v));
    wr(FTS_ADDR_CTRL, 8'h01);
    evt(1'b0);
    evt(1'b1);
    rwait();
    rdc();
    check("no clear", rd, cnt_of(rd, v));
    halt <= 1'b1;
    rdc();
    h = rd;
    rwait();
    rdc();
    check("halted", rd, h);
    halt <= 1'b0;
    wr(FTS_ADDR_CTRL, 8'h13);
    evt(1'b0);
    t0 = cyc;
    rwait();
    ct = cyc - t0 + 2;
    evt(1'b1);
    repeat (2) begin
      rwait();
      rdc();
      check("tx capture", rd, cnt_of(rd, ct));
    end
    wr(FTS_ADDR_CTRL, 8'h0D);
    evt(1'b1);
    t0 = cyc;
    rwait();
    ct = cyc - t0 + 2;
    evt(1'b0);
    repeat (2) begin
      rwait();
      rdc();
      check("rx capture", rd, cnt_of(rd, ct));
    end
    // second reset mid-run, with capture mode on and a nonzero count
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("reset oe", 32'(miso_oe), 32'h0);
    rd_n(FTS_ADDR_CTRL, 1);
    check("reset control", rd, 32'(FTS_CTRL_RST));
    rdc();
    check("reset count", rd, 32'h0);
    // let it run again so that disabling has something to clear
    wr(FTS_ADDR_CTRL, 8'h01);
    rwait();
    wr(FTS_ADDR_CTRL, 8'h00);
    rdc();
    check("disabled", rd, 32'h0);
    conclude();
  end
endmodule
